/* File: hdl/csum_pkg.sv */
// constants and carrier types for the receive checksum and split control
package csum_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses) and write masks
    // ------------------------------------------------------------
    localparam logic [15:0] CPU_VECTOR_RESERVED_OFS = 16'h2c10;
    localparam logic [15:0] RX_CHECKSUM_CONTROL_OFS = 16'h5000;
    localparam logic [15:0] RX_FILTER_CONTROL_OFS = 16'h5008;
    localparam logic [15:0] LINK_CONFIG_OFS = 16'h5010;
    localparam logic [15:0] LAST_RESULT_OFS = 16'h5014;
    localparam logic [31:0] RX_CHECKSUM_CONTROL_RESET = 32'h0000_0300;
    localparam logic [31:0] RX_CHECKSUM_CONTROL_WMASK = 32'h0000_33ff;
    localparam logic [31:0] RX_FILTER_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] RX_FILTER_CONTROL_WMASK = 32'h0000_f3ff;
    localparam logic [31:0] LINK_RESET = 32'h0000_0000;
    localparam logic [31:0] LINK_WMASK = 32'h0000_001f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int START_LSB = 0;
    localparam int IP_SUM_EN_BIT = 8;
    localparam int L4_SUM_EN_BIT = 9;
    localparam int PAYLOAD_SUM_BIT = 12;
    localparam int PKT_SUM_OFF_BIT = 13;
    localparam int STORAGE_OFF_BIT = 0;
    localparam int STORAGE_DW_LSB = 1;
    localparam int FWRITE_OFF_BIT = 6;
    localparam int FREAD_OFF_BIT = 7;
    localparam int FVER_LSB = 8;
    localparam int ACK_OFF_BIT = 12;
    localparam int ACK_RULE_BIT = 13;
    localparam int FRAG_OFF_BIT = 14;
    localparam int EXT_STATUS_BIT = 15;
    localparam int V6_FILTER_OFF_BIT = 16;
    localparam int V6_SUM_OFF_BIT = 17;
    localparam int VLAN_STRIP_BIT = 0;
    localparam int CRC_STRIP_BIT = 1;
    localparam int DTYPE_LSB = 2;
    localparam int PSPLIT_BIT = 4;

    // ------------------------------------------------------------
    // codes and frame offsets
    // ------------------------------------------------------------
    localparam logic [1:0] DTYPE_LEGACY = 2'b00;
    localparam logic [1:0] FVER_RESERVED = 2'b11;
    localparam logic [15:0] ETYPE_V4 = 16'h0800;
    localparam logic [15:0] ETYPE_V6 = 16'h86dd;
    localparam logic [15:0] ETYPE_MIN = 16'h0600;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [15:0] ETYPE_POS = 16'h000c;
    localparam logic [15:0] VLAN_LEN = 16'h0004;
    localparam logic [15:0] SNAP_LEN = 16'h0008;
    localparam logic [15:0] V6_HDR_LEN = 16'h0028;
    localparam int FCS_BYTES = 4;

    typedef struct packed {
        logic ip_checked;
        logic ip_sum_error_flag;
        logic l4_checked;
        logic layer4_sum_error_flag;
        logic ack_event;
        logic ext_status;
        logic split_allowed;
        logic [31:0] sum_field;
    } desc_result_t;

    typedef struct packed {
        logic storage_on;
        logic [4:0] storage_header_dwords;
        logic file_write_on;
        logic file_read_on;
        logic [1:0] file_protocol_version;
    } split_ctrl_t;

endpackage

/* File: hdl/rx_checksum_split_ctrl.sv */
// receive checksum offload, result write-back and header-split control
`timescale 1ns/10ps
module rx_checksum_split_ctrl (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // receive byte stream
    input wire logic RX_VALID,
    input wire logic RX_SOP,
    input wire logic RX_EOP,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VLAN,
    input wire logic [31:0] RX_FLOW_HASH,
    // descriptor write-back and split control
    output logic DESC_VALID,
    output csum_pkg::desc_result_t DESC_OUT,
    output csum_pkg::split_ctrl_t SPLIT_CTRL
);

    function automatic logic [15:0] oc_add(input logic [15:0] a,
                                           input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] rx_checksum_control_r, rx_filter_control_r, link_r, prdata_r;
    logic pready_r, pslverr_r;
    logic [31:0] last_r;

    wire acc_phase = PSEL & PENABLE;
    wire sel_csum = PADDR == csum_pkg::RX_CHECKSUM_CONTROL_OFS;
    wire sel_filt = PADDR == csum_pkg::RX_FILTER_CONTROL_OFS;
    wire sel_link = PADDR == csum_pkg::LINK_CONFIG_OFS;
    wire sel_last = PADDR == csum_pkg::LAST_RESULT_OFS;
    wire sel_cpuv = PADDR == csum_pkg::CPU_VECTOR_RESERVED_OFS;
    wire mapped = sel_csum | sel_filt | sel_link | sel_last | sel_cpuv;
    wire wr_go = acc_phase & pready_r & PWRITE;
    // reserved bits are masked at write, so they read zero
    wire [31:0] wr_csum = PWDATA & csum_pkg::RX_CHECKSUM_CONTROL_WMASK;
    wire [31:0] wr_filt = PWDATA & csum_pkg::RX_FILTER_CONTROL_WMASK;
    wire [31:0] wr_link = PWDATA & csum_pkg::LINK_WMASK;
    wire [31:0] rd_mux = sel_csum ? rx_checksum_control_r :
                         sel_filt ? rx_filter_control_r :
                         sel_link ? link_r :
                         sel_last ? last_r : 32'h0000_0000;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc_phase & ~pready_r;
            pslverr_r <= acc_phase & ~pready_r & ~mapped;
            prdata_r <= (acc_phase & ~pready_r & ~PWRITE) ? rd_mux
                                                         : 32'h0000_0000;
        end
    end

    // the control registers are meant to change only while reception is
    // stopped; writes mid-packet are accepted but give a mixed result
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rx_checksum_control_r <= csum_pkg::RX_CHECKSUM_CONTROL_RESET;
            rx_filter_control_r <= csum_pkg::RX_FILTER_CONTROL_RESET;
            link_r <= csum_pkg::LINK_RESET;
        end else if (wr_go) begin
            if (sel_csum) rx_checksum_control_r <= wr_csum;
            if (sel_filt) rx_filter_control_r <= wr_filt;
            if (sel_link) link_r <= wr_link;
        end
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire [7:0] start_ofs = rx_checksum_control_r[csum_pkg::START_LSB +: 8];
    wire ip_en = rx_checksum_control_r[csum_pkg::IP_SUM_EN_BIT];
    wire l4_en = rx_checksum_control_r[csum_pkg::L4_SUM_EN_BIT];
    wire payload_en = rx_checksum_control_r[csum_pkg::PAYLOAD_SUM_BIT];
    wire pkt_sum_off = rx_checksum_control_r[csum_pkg::PKT_SUM_OFF_BIT];
    wire ack_off = rx_filter_control_r[csum_pkg::ACK_OFF_BIT];
    wire ack_rule = rx_filter_control_r[csum_pkg::ACK_RULE_BIT];
    wire frag_off = rx_filter_control_r[csum_pkg::FRAG_OFF_BIT];
    wire ext_on = rx_filter_control_r[csum_pkg::EXT_STATUS_BIT];
    // v6 control bits live in the reserved range, so they always read 0
    wire v6_off = rx_filter_control_r[csum_pkg::V6_FILTER_OFF_BIT] |
                  rx_filter_control_r[csum_pkg::V6_SUM_OFF_BIT];
    wire vlan_strip = link_r[csum_pkg::VLAN_STRIP_BIT];
    wire crc_strip = link_r[csum_pkg::CRC_STRIP_BIT];
    wire [1:0] dtype = link_r[csum_pkg::DTYPE_LSB +: 2];
    wire psplit = link_r[csum_pkg::PSPLIT_BIT];

    // ------------------------------------------------------------
    // stream position
    // ------------------------------------------------------------
    logic [15:0] raw_idx_r, pos_r;
    logic vlan_r;
    wire [15:0] raw_idx = RX_SOP ? 16'h0000 : raw_idx_r;
    wire [15:0] p = RX_SOP ? 16'h0000 : pos_r;
    wire vlan_now = RX_SOP ? RX_VLAN : vlan_r;
    // stripped tag bytes never reach the position counter
    wire drop = vlan_now & vlan_strip & (raw_idx >= csum_pkg::ETYPE_POS) &
                (raw_idx < csum_pkg::ETYPE_POS + csum_pkg::VLAN_LEN);
    wire take = RX_VALID & ~drop;
    wire [15:0] raw_idx_nxt = RX_VALID ? raw_idx + 16'h0001 : raw_idx_r;
    wire [15:0] pos_nxt = take ? p + 16'h0001 : p;

    // ------------------------------------------------------------
    // frame type and ip header parse
    // ------------------------------------------------------------
    logic [15:0] etype_r, etype2_r, len_r, ip_id_r;
    logic [7:0] proto_r, tcp_doff_r;
    logic [3:0] ihl_r;
    logic v4_r, v6_r, frag_r, tcp_ack_r;
    wire [15:0] e0 = (vlan_now & ~vlan_strip) ?
                     csum_pkg::ETYPE_POS + csum_pkg::VLAN_LEN :
                     csum_pkg::ETYPE_POS;
    // a length below the type threshold means an llc/snap frame
    wire snap = etype_r < csum_pkg::ETYPE_MIN;
    wire [15:0] l3_type = snap ? etype2_r : etype_r;
    wire [15:0] ip_base = snap ? e0 + 16'h0002 + csum_pkg::SNAP_LEN
                               : e0 + 16'h0002;
    wire in_ip = p >= ip_base;
    wire [15:0] rel = p - ip_base;
    wire at0 = in_ip & (rel == 16'h0000);
    wire v4_now = at0 ? (l3_type == csum_pkg::ETYPE_V4) &
                        (RX_DATA[7:4] == 4'h4) : v4_r;
    wire v6_now = at0 ? (l3_type == csum_pkg::ETYPE_V6) &
                        (RX_DATA[7:4] == 4'h6) : v6_r;
    wire [3:0] ihl_now = at0 ? RX_DATA[3:0] : ihl_r;
    wire [15:0] hdr_len = v4_now ? {10'h000, ihl_now, 2'b00}
                                 : csum_pkg::V6_HDR_LEN;
    wire [15:0] l4_end = v4_now ? len_r : csum_pkg::V6_HDR_LEN + len_r;
    wire [15:0] l4_len = l4_end - hdr_len;
    wire [15:0] l4_rel = rel - hdr_len;
    wire in_hdr = in_ip & v4_now & (rel < hdr_len);
    wire in_l4 = in_ip & (v4_now | v6_now) & (rel >= hdr_len) &
                 (rel < l4_end);
    wire in_addr = in_ip & ((v4_now & rel >= 16'd12 & rel < 16'd20) |
                            (v6_now & rel >= 16'd8 & rel < 16'd40));
    wire [15:0] ip_lane = rel[0] ? {8'h00, RX_DATA} : {RX_DATA, 8'h00};

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            raw_idx_r <= 16'h0000;
            pos_r <= 16'h0000;
            vlan_r <= 1'b0;
        end else begin
            raw_idx_r <= raw_idx_nxt;
            pos_r <= pos_nxt;
            vlan_r <= vlan_now;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST | (RX_VALID & RX_SOP)) begin
            etype_r <= 16'hffff;
            etype2_r <= 16'h0000;
            {len_r, ip_id_r, proto_r, tcp_doff_r} <= '0;
            {ihl_r, v4_r, v6_r, frag_r, tcp_ack_r} <= '0;
        end else if (take) begin
            v4_r <= v4_now;
            v6_r <= v6_now;
            ihl_r <= ihl_now;
            if (p == e0) etype_r[15:8] <= RX_DATA;
            if (p == e0 + 16'h0001) etype_r[7:0] <= RX_DATA;
            if (p == e0 + 16'h0008) etype2_r[15:8] <= RX_DATA;
            if (p == e0 + 16'h0009) etype2_r[7:0] <= RX_DATA;
            if (in_ip & v4_now) begin
                if (rel == 16'd2) len_r[15:8] <= RX_DATA;
                if (rel == 16'd3) len_r[7:0] <= RX_DATA;
                if (rel == 16'd4) ip_id_r[15:8] <= RX_DATA;
                if (rel == 16'd5) ip_id_r[7:0] <= RX_DATA;
                if (rel == 16'd6) frag_r <= RX_DATA[5] | |RX_DATA[4:0];
                if (rel == 16'd7) frag_r <= frag_r | |RX_DATA;
                if (rel == 16'd9) proto_r <= RX_DATA;
            end
            if (in_ip & v6_now) begin
                if (rel == 16'd4) len_r[15:8] <= RX_DATA;
                if (rel == 16'd5) len_r[7:0] <= RX_DATA;
                if (rel == 16'd6) proto_r <= RX_DATA;
            end
            if (in_l4 & (l4_rel == 16'd12)) tcp_doff_r <= RX_DATA;
            if (in_l4 & (l4_rel == 16'd13)) tcp_ack_r <= RX_DATA[4];
        end
    end

    // ------------------------------------------------------------
    // sums
    // ------------------------------------------------------------
    logic [15:0] ip_sum_r, l4_sum_r, raw_sum_r;
    logic [15:0] hist_r [csum_pkg::FCS_BYTES];
    wire [15:0] ip_sum = RX_SOP ? 16'h0000 : ip_sum_r;
    wire [15:0] l4_sum = RX_SOP ? 16'h0000 : l4_sum_r;
    wire [15:0] raw_sum = RX_SOP ? 16'h0000 : raw_sum_r;
    // payload mode starts at the v4 payload; unknown start means not yet
    wire [15:0] start_eff = ~payload_en ? {8'h00, start_ofs} :
                            v4_now ? ip_base + hdr_len : 16'hffff;
    wire raw_on = p >= start_eff;
    wire [15:0] raw_rel = p - start_eff;
    wire [15:0] raw_lane = raw_rel[0] ? {8'h00, RX_DATA}
                                      : {RX_DATA, 8'h00};
    wire [15:0] ip_sum_nxt = in_hdr ? oc_add(ip_sum, ip_lane) : ip_sum;
    wire [15:0] l4_sum_nxt = (in_l4 | in_addr) ? oc_add(l4_sum, ip_lane)
                                               : l4_sum;
    // plain end-around-carry sum, no pseudo header adjustment
    wire [15:0] raw_sum_nxt = raw_on ? oc_add(raw_sum, raw_lane) : raw_sum;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ip_sum_r <= 16'h0000;
            l4_sum_r <= 16'h0000;
            raw_sum_r <= 16'h0000;
        end else if (take) begin
            ip_sum_r <= ip_sum_nxt;
            l4_sum_r <= l4_sum_nxt;
            raw_sum_r <= raw_sum_nxt;
        end
    end

    // sum as it stood before each of the last four bytes, so the fcs
    // can be backed out at the end without a byte delay line
    genvar gi;
    generate
        for (gi = 0; gi < csum_pkg::FCS_BYTES; gi++) begin : g_hist
            wire [15:0] h_in;
            if (gi == 0) begin : g_first
                assign h_in = raw_sum;
            end else begin : g_rest
                assign h_in = hist_r[gi - 1];
            end
            always_ff @(posedge CORE_CLK) begin
                if (SYS_RST) begin
                    hist_r[gi] <= 16'h0000;
                end else if (take) begin
                    hist_r[gi] <= h_in;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // packet end: checks and descriptor result
    // ------------------------------------------------------------
    logic done_r, desc_valid_r;
    logic [31:0] hash_r;
    csum_pkg::desc_result_t desc_r;
    csum_pkg::split_ctrl_t split_r;

    wire [15:0] pseudo = oc_add(oc_add(l4_sum_r, {8'h00, proto_r}), l4_len);
    wire is_tcp = proto_r == csum_pkg::PROTO_TCP;
    wire is_l4 = is_tcp | (proto_r == csum_pkg::PROTO_UDP);
    wire ip_chk = ip_en & v4_r;
    wire l4_chk = l4_en & is_l4 & ((v4_r & ~frag_r) |
                                   (v6_r & ~v6_off));
    wire [15:0] tcp_data = l4_len - {10'h000, tcp_doff_r[7:4], 2'b00};
    wire ack_seen = is_tcp & (v4_r | v6_r) & tcp_ack_r &
                    (~ack_rule | tcp_data == 16'h0000);
    // fcs drop: take the sum from four bytes back
    wire [15:0] pkt_sum = crc_strip ? hist_r[csum_pkg::FCS_BYTES - 1]
                                    : raw_sum_r;
    // legacy type ignores the disable bit, which must stay clear
    wire use_hash = (dtype != csum_pkg::DTYPE_LEGACY) & pkt_sum_off;
    wire [31:0] field = dtype == csum_pkg::DTYPE_LEGACY ?
                        {16'h0000, pkt_sum} :
                        use_hash ? hash_r : {ip_id_r, pkt_sum};
    csum_pkg::desc_result_t res;
    assign res.ip_checked = ip_chk;
    assign res.ip_sum_error_flag = ip_chk & (ip_sum_r != 16'hffff);
    assign res.l4_checked = l4_chk;
    assign res.layer4_sum_error_flag = l4_chk & (pseudo != 16'hffff);
    assign res.ack_event = ack_seen & ~ack_off;
    assign res.ext_status = ext_on | psplit;
    assign res.split_allowed = ~(frag_r & frag_off);
    assign res.sum_field = field;

    wire [1:0] fver = rx_filter_control_r[csum_pkg::FVER_LSB +: 2];
    wire fver_ok = fver != csum_pkg::FVER_RESERVED;
    csum_pkg::split_ctrl_t split_nxt;
    assign split_nxt.storage_on = ~rx_filter_control_r[csum_pkg::STORAGE_OFF_BIT];
    assign split_nxt.storage_header_dwords =
        rx_filter_control_r[csum_pkg::STORAGE_DW_LSB +: 5];
    assign split_nxt.file_write_on =
        ~rx_filter_control_r[csum_pkg::FWRITE_OFF_BIT] & fver_ok;
    assign split_nxt.file_read_on =
        ~rx_filter_control_r[csum_pkg::FREAD_OFF_BIT] & fver_ok;
    assign split_nxt.file_protocol_version = fver;

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            done_r <= 1'b0;
            desc_valid_r <= 1'b0;
            hash_r <= 32'h0000_0000;
            desc_r <= '0;
            split_r <= '0;
            last_r <= 32'h0000_0000;
        end else begin
            done_r <= RX_VALID & RX_EOP;
            desc_valid_r <= done_r;
            if (RX_VALID & RX_SOP) hash_r <= RX_FLOW_HASH;
            if (done_r) desc_r <= res;
            if (done_r) last_r <= {pkt_sum, 9'h000, res[38:32]};
            split_r <= split_nxt;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign DESC_VALID = desc_valid_r;
    assign DESC_OUT = desc_r;
    assign SPLIT_CTRL = split_r;

endmodule

/* File: bench/rx_csum_asserts.sv */
// assertion checker for the receive checksum and split control block
`timescale 1ns/10ps
module rx_csum_asserts (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [15:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // stream and results
    input wire logic RX_VALID,
    input wire logic RX_EOP,
    input wire logic DESC_VALID,
    input wire csum_pkg::desc_result_t DESC_OUT,
    input wire csum_pkg::split_ctrl_t SPLIT_CTRL
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    wire is_filt = PADDR == csum_pkg::RX_FILTER_CONTROL_OFS;
    wire is_csum = PADDR == csum_pkg::RX_CHECKSUM_CONTROL_OFS;
    wire mapped = is_filt || is_csum ||
        PADDR inside {csum_pkg::CPU_VECTOR_RESERVED_OFS,
        csum_pkg::LINK_CONFIG_OFS, csum_pkg::LAST_RESULT_OFS};
    wire [31:0] rsvd_bits = is_filt ? ~32'h0000_f3ff : ~32'h0000_33ff;

    sequence access_s;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence eop_s;
        RX_VALID && RX_EOP;
    endsequence
    sequence pulse_s;
        DESC_VALID ##1 !DESC_VALID;
    endsequence

    apb_wait_a: assert property (access_s |=> PREADY)
        else $error("access phase not answered after one wait");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    slverr_map_a: assert property (PREADY |-> PSLVERR == !mapped)
        else $error("slave error does not match address map");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside answer cycle");
    rsvd_zero_a: assert property (
        PREADY && !PWRITE && (is_filt || is_csum) |->
        (PRDATA & rsvd_bits) == 32'h0)
        else $error("reserved bits read nonzero");
    desc_lat_a: assert property (eop_s |-> ##2 pulse_s)
        else $error("result not pulsed two cycles after last byte");
    desc_hold_a: assert property (!DESC_VALID |-> $stable(DESC_OUT))
        else $error("result changed without valid");
    fver_rsvd_a: assert property (
        SPLIT_CTRL.file_protocol_version == csum_pkg::FVER_RESERVED |->
        !SPLIT_CTRL.file_write_on && !SPLIT_CTRL.file_read_on)
        else $error("reserved file version left splits on");
    flag_cause_a: assert property (DESC_VALID |->
        !(DESC_OUT.ip_sum_error_flag && !DESC_OUT.ip_checked) &&
        !(DESC_OUT.layer4_sum_error_flag && !DESC_OUT.l4_checked))
        else $error("error flag without a check");
endmodule
bind rx_checksum_split_ctrl rx_csum_asserts u_rx_csum_asserts (.*);

/* File: bench/rx_stream_src.sv */
// receive byte stream source standing in for the mac receive path
`timescale 1ns/10ps
module rx_stream_src (
    // clock
    input wire logic CORE_CLK,
    // byte stream
    output logic RX_VALID,
    output logic RX_SOP,
    output logic RX_EOP,
    output logic [7:0] RX_DATA,
    output logic RX_VLAN,
    output logic [31:0] RX_FLOW_HASH
);
    logic [7:0] pkt [0:63];
    initial {RX_VALID, RX_SOP, RX_EOP, RX_DATA, RX_VLAN, RX_FLOW_HASH} = '0;
    // idle and qualifier lines show inverted values so stale data cannot pass
    task automatic send(input int len, input logic vlan,
                        input logic [31:0] hash, input logic slow);
        for (int i = 0; i < len; i++) begin
            @(posedge CORE_CLK);
            {RX_VALID, RX_SOP, RX_EOP} <= {1'b1, i == 0, i == len - 1};
            RX_DATA <= pkt[i];
            RX_VLAN <= (i == 0) ? vlan : ~vlan;
            RX_FLOW_HASH <= (i == 0) ? hash : ~hash;
            if (slow && i < len - 1) begin
                @(posedge CORE_CLK);
                {RX_VALID, RX_SOP, RX_EOP} <= 3'b000;
                RX_DATA <= ~pkt[i];
            end
        end
        @(posedge CORE_CLK);
        {RX_VALID, RX_SOP, RX_EOP} <= 3'b000;
        RX_DATA <= ~pkt[len - 1];
    endtask
endmodule

/* File: bench/rx_checksum_split_ctrl_tb.sv */
// self-checking bench for the receive checksum and split control block
`timescale 1ns/10ps
module rx_checksum_split_ctrl_tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rx_flow_hash, rd, filt;
    logic pready, pslverr, rx_valid, rx_sop, rx_eop, rx_vlan, desc_valid, err;
    logic [7:0] rx_data;
    csum_pkg::desc_result_t desc_out;
    csum_pkg::split_ctrl_t split_ctrl;
    int error_cnt = 0, comparisons = 0, cyc = 0;

    always #5 core_clk = ~core_clk;

    rx_checksum_split_ctrl u_rx_checksum_split_ctrl (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RX_VALID(rx_valid), .RX_SOP(rx_sop), .RX_EOP(rx_eop),
        .RX_DATA(rx_data), .RX_VLAN(rx_vlan), .RX_FLOW_HASH(rx_flow_hash),
        .DESC_VALID(desc_valid), .DESC_OUT(desc_out), .SPLIT_CTRL(split_ctrl)
    );
    rx_stream_src u_rx_stream_src (
        .CORE_CLK(core_clk), .RX_VALID(rx_valid), .RX_SOP(rx_sop),
        .RX_EOP(rx_eop), .RX_DATA(rx_data), .RX_VLAN(rx_vlan),
        .RX_FLOW_HASH(rx_flow_hash)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic filt_wr(input logic [31:0] d, input logic [9:0] e);
        apb(1'b1, csum_pkg::RX_FILTER_CONTROL_OFS, d);
        filt = d;
        apb(1'b0, csum_pkg::RX_FILTER_CONTROL_OFS, 32'h0);
        check(rd, d & 32'h0000_f3ff, "filter readback");
        check({22'h0, split_ctrl}, {22'h0, e}, "split control");
    endtask
    // frame of pattern bytes, optionally an ipv4 header with a given sum
    task automatic mk(input logic ip, input logic [15:0] ck);
        logic [15:0] hw [0:10];
        hw = '{16'h0800, 16'h4500, 16'h0014, 16'h1234, 16'h0000,
               16'h40ff, ck, 16'h0, 16'h0, 16'h0, 16'h0};
        for (int i = 0; i < 64; i++) u_rx_stream_src.pkt[i] = 8'(i * 7 + 3);
        for (int k = 0; k < 11 && ip; k++)
            {u_rx_stream_src.pkt[12 + 2 * k],
             u_rx_stream_src.pkt[13 + 2 * k]} = hw[k];
    endtask
    function automatic logic [15:0] exp_sum(int st, int len, logic sv,
                                            logic sc);
        logic [7:0] b [$];
        logic [16:0] acc;
        acc = 17'h0;
        for (int j = 0; j < len; j++)
            if (!(sv && j >= 12 && j < 16)) b.push_back(u_rx_stream_src.pkt[j]);
        for (int k = st; k < b.size() - (sc ? 4 : 0); k++) begin
            acc = acc + (((k - st) % 2 == 0) ? {b[k], 8'h00} : b[k]);
            acc = acc[15:0] + acc[16];
        end
        return acc[15:0];
    endfunction
    task automatic pkt_run(input logic [31:0] cs, input logic [4:0] lk,
        input logic vl, input int len, input logic slow, input logic [1:0] ipx);
        logic [15:0] raw;
        logic [31:0] se;
        int n;
        raw = exp_sum(cs[12] ? 34 : cs[7:0], len, lk[0] & vl, lk[1]);
        se = {16'h0, raw};
        if (lk[3:2] == 2'b01)
            se = cs[13] ? 32'h5a5a_c3c3 : {u_rx_stream_src.pkt[18],
                                           u_rx_stream_src.pkt[19], raw};
        apb(1'b1, csum_pkg::RX_CHECKSUM_CONTROL_OFS, cs);
        apb(1'b1, csum_pkg::LINK_CONFIG_OFS, {27'h0, lk});
        u_rx_stream_src.send(len, vl, 32'h5a5a_c3c3, slow);
        for (n = 0; n < 8 && desc_valid !== 1'b1; n++) @(posedge core_clk);
        check({31'h0, desc_valid}, 32'h1, "result pulse");
        check({30'h0, desc_out.ip_checked, desc_out.ip_sum_error_flag},
              {30'h0, ipx}, "ip flags");
        check({27'h0, desc_out.l4_checked, desc_out.layer4_sum_error_flag,
               desc_out.ack_event, desc_out.ext_status,
               desc_out.split_allowed}, {27'h0, 3'b000, filt[15] | lk[4],
               !(filt[14] && u_rx_stream_src.pkt[20][5])},
              "status flags");
        check(desc_out.sum_field, se, "sum field");
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("ERROR at %0t: timeout", $time);
            stop_test();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({22'h0, split_ctrl}, 32'h0000_020c, "split after reset");
        apb(1'b0, csum_pkg::RX_CHECKSUM_CONTROL_OFS, 32'h0);
        check(rd, 32'h0000_0300, "checksum ctrl reset");
        apb(1'b0, csum_pkg::CPU_VECTOR_RESERVED_OFS, 32'h0);
        check({rd[30:0], err}, 32'h0, "reserved vector");
        apb(1'b0, 16'h5004, 32'h0);
        check({rd[30:0], err}, 32'h1, "unmapped read");
        $display("test registers done");
        // all writes happen with no frame in flight
        filt_wr(32'hffff_ffff, 10'h1f3);
        filt_wr(32'h0000_0042, 10'h214);
        for (int v = 0; v < 4; v++)
            filt_wr({22'h0, 2'(v), 8'h80},
                    (v == 3) ? 10'h203 : 10'h208 | 10'(v));
        apb(1'b1, csum_pkg::RX_CHECKSUM_CONTROL_OFS, 32'hffff_ffff);
        apb(1'b0, csum_pkg::RX_CHECKSUM_CONTROL_OFS, 32'h0);
        check(rd, 32'h0000_33ff, "checksum ctrl mask");
        filt_wr(32'h0000_8000, 10'h20c);
        $display("test filter done");
        // start is byte 0, the ip header or the v4 payload, and the disable bit gives the flow hash in the non-legacy type,
        mk(1'b0, 16'h0);
        pkt_run(32'h0000_000e, 5'h02, 1'b0, 24, 1'b0, 2'b00);
        pkt_run(32'h0000_000e, 5'h00, 1'b0, 24, 1'b1, 2'b00);
        pkt_run(32'h0000_0000, 5'h03, 1'b1, 24, 1'b0, 2'b00);
        pkt_run(32'h0000_200e, 5'h06, 1'b0, 24, 1'b0, 2'b00);
        mk(1'b1, 16'h67b8);
        pkt_run(32'h0000_010e, 5'h06, 1'b0, 38, 1'b0, 2'b10);
        pkt_run(32'h0000_000e, 5'h02, 1'b0, 38, 1'b0, 2'b00);
        pkt_run(32'h0000_100e, 5'h00, 1'b0, 38, 1'b0, 2'b00);
        filt_wr(32'h0, 10'h20c);
        mk(1'b1, 16'h67b9);
        pkt_run(32'h0000_010e, 5'h12, 1'b0, 38, 1'b1, 2'b11);
        u_rx_stream_src.pkt[20] = 8'h20;
        filt_wr(32'h0000_4000, 10'h20c);
        pkt_run(32'h0000_010e, 5'h02, 1'b0, 38, 1'b0, 2'b11);
        $display("test packets done");
        stop_test();
    end
endmodule
